// *** hw/psc_regs.sv ***
// Purpose: Strap status, expanded control and interrupt control/status
//          registers behind the serial management port.
// Assumes: MDC and MDIO are far slower than mclk; events are on mclk.
// Notes:   Other register numbers read as zero from this bank.
`timescale 1ns/100ps
`include "psc_params.svh"

// Operation
// - Strap bit 6 reads 1 when strapped for RMII repeater pairing, RMII only.
// - Strap bit 5 reads 1 when strapped for pin chain test; read-only.
// - Strap bit 1 reads 1 when strapped to RMII, RMII variant only.
// - Strap bit 0 reads 1 when strapped to MII, MII variant only.
// - Control bit 11 disables energy-sense power-down; resets to 1.
// - Control bit 10 picks variable receive latency, MII only; resets 0.
// - Control bit 6 restores preamble; 0 strips it to the SFD.
// - Interrupt bits 15 to 8 are enables, reset 0, writable.
// - Bit 7 flags jabber; all flags read-only, reset 0, cleared by read.
// - Bit 6 flags a receive error since last cleared.
// - Bit 5 flags a received auto-negotiation page.
// - Bit 4 flags a parallel detection fault.
// - Bit 3 flags link partner acknowledge seen.
// - Bit 2 flags link going from up to down.
// - Bit 1 flags a remote fault from the partner.
// - Bit 0 flags link going from down to up.
module psc_regs
	import psc_pkg::*;
#(
	parameter bit RMII_VARIANT = 1'b1,    // 1 RMII part, 0 MII part
	parameter int PRE_LEN      = `PSC_PRE_LEN // Preamble ones needed
)(
	input  wire logic       mclk,         // Core clock, 200 MHz
	input  wire logic       rst,          // Async reset, high
	input  wire logic       mdc,          // Management clock pin
	input  wire logic       mdio_in,      // Management data pin level
	output logic            mdio_out,     // Management data drive value
	output logic            mdio_oe,      // Management data drive enable
	input  wire logic [2:0] strap_phy_addr, // Address straps
	input  wire logic       strap_repeater_pairing, // Pairing strap
	input  wire logic       strap_chain_test, // Pin chain test strap
	input  wire logic       strap_rmii,   // RMII interface strap
	input  wire logic       strap_mii,    // MII interface strap
	input  wire logic [7:0] evt,          // Event pulses, jabber at 7
	output logic            energy_sense_powerdown_dis, // Power-down off
	output logic            rx_latency_variable, // Variable rx latency
	output logic            preamble_restore, // Keep rx preamble
	output logic            irq           // Interrupt, high
);

	// Assertion clock and reset for the whole module
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// ------------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------------
	logic [8:0]   pins_s;
	logic         mdc_s;
	logic         mdio_s;
	logic         mdc_d;
	logic         mdc_rise;
	logic         strap_done;

	psc_sync #(
		.W (9)
	) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    ({mdc, mdio_in, strap_phy_addr, strap_repeater_pairing,
		        strap_chain_test, strap_rmii, strap_mii}),
		.q    (pins_s)
	);

	assign mdc_s  = pins_s[8];
	assign mdio_s = pins_s[7];

	// MDC edge detector on the filtered level
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mdc_d <= 1'b0;
		end else begin
			mdc_d <= mdc_s;
		end
	end

	// No rise before straps latch: filter steps from reset low to idle high
	assign mdc_rise = mdc_s & ~mdc_d & strap_done;

	// ------------------------------------------------------------------
	// Strap capture after reset release
	// ------------------------------------------------------------------
	logic [2:0]   settle;
	logic [2:0]   phy_addr;
	logic         strap_pair;
	logic         strap_chain;
	logic         strap_is_rmii;
	logic         strap_is_mii;

	// Wait for the synchroniser to fill, then latch once
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			settle     <= 3'h0;
			strap_done <= 1'b0;
		end else if (!strap_done) begin
			settle     <= settle + 3'h1;
			strap_done <= (settle == `PSC_STRAP_SETTLE);
		end
	end

	// Straps never change once latched
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			phy_addr      <= 3'h0;
			strap_pair    <= 1'b0;
			strap_chain   <= 1'b0;
			strap_is_rmii <= 1'b0;
			strap_is_mii  <= 1'b0;
		end else if (!strap_done && settle == `PSC_STRAP_SETTLE) begin
			phy_addr      <= pins_s[6:4];
			strap_pair    <= pins_s[3] & RMII_VARIANT;
			strap_chain   <= pins_s[2];
			strap_is_rmii <= pins_s[1] & RMII_VARIANT;
			strap_is_mii  <= pins_s[0] & ~RMII_VARIANT;
		end
	end

	// ------------------------------------------------------------------
	// Management frame receiver
	// ------------------------------------------------------------------
	psc_mdio_st_t st;
	logic [5:0]   cnt;
	logic [13:0]  hdr;
	logic [13:0]  next_hdr;
	logic [4:0]   reg_q;
	logic         hdr_ok;
	logic [5:0]   pre_full;
	psc_word_t    wdat;
	psc_word_t    wr_word;
	logic         wr_stb;
	logic         rd_load;
	psc_word_t    rsh;

	assign pre_full = 6'(PRE_LEN);
	assign next_hdr = {hdr[12:0], mdio_s};
	// Start code, our address, and a known opcode
	assign hdr_ok = (next_hdr[13:12] == `PSC_START)
		&& (next_hdr[9:5] == {2'h0, phy_addr})
		&& ((next_hdr[11:10] == `PSC_OP_RD)
		|| (next_hdr[11:10] == `PSC_OP_WR));
	assign rd_load = mdc_rise && (st == MS_TA1);
	assign wr_stb  = mdc_rise && (st == MS_WR) && (cnt == 6'd15);
	assign wr_word = {wdat[14:0], mdio_s};

	// Frame sequencing on each MDC rising edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st    <= MS_PRE;
			cnt   <= 6'd0;
			hdr   <= 14'h0;
			reg_q <= 5'h0;
		end else if (mdc_rise) begin
			unique case (st)
			MS_PRE: begin
				if (mdio_s) begin
					if (cnt != pre_full) begin
						cnt <= cnt + 6'd1;
					end
				end else if (cnt == pre_full) begin
					st  <= MS_HDR;
					cnt <= 6'd1;
					hdr <= 14'h0;
				end else begin
					cnt <= 6'd0;
				end
			end
			MS_HDR: begin
				hdr <= next_hdr;
				cnt <= cnt + 6'd1;
				if (cnt == 6'd13) begin
					cnt   <= 6'd0;
					reg_q <= next_hdr[4:0];
					if (!hdr_ok) begin
						st <= MS_PRE;
					end else if (next_hdr[11:10] == `PSC_OP_RD) begin
						st <= MS_TA1;
					end else begin
						st <= MS_WTA;
					end
				end
			end
			MS_TA1: begin
				st <= MS_TA2;
			end
			MS_TA2: begin
				st  <= MS_RD;
				cnt <= 6'd0;
			end
			MS_RD: begin
				if (cnt == 6'd15) begin
					st  <= MS_PRE;
					cnt <= 6'd0;
				end else begin
					cnt <= cnt + 6'd1;
				end
			end
			MS_WTA: begin
				if (cnt == 6'd1) begin
					st  <= MS_WR;
					cnt <= 6'd0;
				end else begin
					cnt <= cnt + 6'd1;
				end
			end
			MS_WR: begin
				if (cnt == 6'd15) begin
					st  <= MS_PRE;
					cnt <= 6'd0;
				end else begin
					cnt <= cnt + 6'd1;
				end
			end
			endcase
		end
	end

	// Write data shifter
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wdat <= 16'h0;
		end else if (mdc_rise && st == MS_WR) begin
			wdat <= wr_word;
		end
	end

	// ------------------------------------------------------------------
	// Control and enable registers
	// ------------------------------------------------------------------
	logic [7:0]   irq_en;
	logic [7:0]   flags;
	logic         flag_clr;

	// Only the three defined control bits take write data
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			energy_sense_powerdown_dis <= `PSC_ESPD_RST;
			rx_latency_variable        <= `PSC_LAT_RST;
			preamble_restore           <= `PSC_PRE_RST;
		end else if (wr_stb && reg_q == `PSC_REG_EXPCTL) begin
			energy_sense_powerdown_dis <= wr_word[`PSC_BIT_ESPD];
			rx_latency_variable <= wr_word[`PSC_BIT_LAT]
				& ~RMII_VARIANT;
			preamble_restore <= wr_word[`PSC_BIT_PRE];
		end
	end

	// Event enables; flag bits of the write are dropped
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_en <= `PSC_EN_RST;
		end else if (wr_stb && reg_q == `PSC_REG_INTCS) begin
			irq_en <= wr_word[15:8];
		end
	end

	// Reading the event register clears its flags
	assign flag_clr = rd_load && (reg_q == `PSC_REG_INTCS);

	psc_event_flags #(
		.W (8)
	) u_flags (
		.mclk  (mclk),
		.rst   (rst),
		.evt   (evt),
		.clr   (flag_clr),
		.en    (irq_en),
		.flags (flags),
		.irq   (irq)
	);

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	// Register image for a given number; unknown numbers read zero
	function automatic psc_word_t psc_rd_word(input logic [4:0] a);
		psc_word_t w;
		w = 16'h0;
		if (a == `PSC_REG_STRAP) begin
			w[`PSC_BIT_PAIR]  = strap_pair;
			w[`PSC_BIT_CHAIN] = strap_chain;
			w[`PSC_BIT_RMII]  = strap_is_rmii;
			w[`PSC_BIT_MII]   = strap_is_mii;
		end else if (a == `PSC_REG_EXPCTL) begin
			w[5:0]           = `PSC_EXPCTL_LOW;
			w[`PSC_BIT_ESPD] = energy_sense_powerdown_dis;
			w[`PSC_BIT_LAT]  = rx_latency_variable;
			w[`PSC_BIT_PRE]  = preamble_restore;
		end else if (a == `PSC_REG_INTCS) begin
			w = {irq_en, flags};
		end
		return w;
	endfunction

	// Read shifter: load in first turnaround bit, then MSB first
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rsh <= 16'h0;
		end else if (rd_load) begin
			rsh <= psc_rd_word(reg_q);
		end else if (mdc_rise && (st == MS_TA2 || st == MS_RD)) begin
			rsh <= {rsh[14:0], 1'b0};
		end
	end

	// Pin drive: zero in second turnaround bit, then data
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mdio_out <= 1'b0;
			mdio_oe  <= 1'b0;
		end else if (mdc_rise) begin
			if (st == MS_TA1) begin
				mdio_out <= 1'b0;
				mdio_oe  <= 1'b1;
			end else if (st == MS_TA2) begin
				mdio_out <= rsh[15];
			end else if (st == MS_RD && cnt != 6'd15) begin
				mdio_out <= rsh[15];
			end else begin
				mdio_out <= 1'b0;
				mdio_oe  <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence s_strap_read;
		rd_load && reg_q == `PSC_REG_STRAP;
	endsequence

	sequence s_ctl_write;
		wr_stb && reg_q == `PSC_REG_EXPCTL;
	endsequence

	sequence s_turnaround;
		rd_load ##1 (!mdc_rise)[*1];
	endsequence

	chk_pair_strap_bit: assert property (
		s_strap_read |=> rsh[`PSC_BIT_PAIR] == (strap_pair && RMII_VARIANT))
		else $error("pairing strap bit wrong");

	chk_chain_strap_bit: assert property (
		s_strap_read |=> rsh[`PSC_BIT_CHAIN] == strap_chain)
		else $error("chain test strap bit wrong");

	chk_rmii_strap_bit: assert property (
		s_strap_read |=> rsh[`PSC_BIT_RMII] == (strap_is_rmii && RMII_VARIANT))
		else $error("rmii strap bit wrong");

	chk_mii_strap_bit: assert property (
		s_strap_read |=> rsh[`PSC_BIT_MII] == (strap_is_mii && !RMII_VARIANT))
		else $error("mii strap bit wrong");

	chk_espd_write: assert property (
		s_ctl_write |=> energy_sense_powerdown_dis == $past(wr_word[11]))
		else $error("power-down disable not written");

	chk_ctl_hold: assert property (
		!(wr_stb && reg_q == `PSC_REG_EXPCTL) |=> $stable(
		{energy_sense_powerdown_dis, rx_latency_variable, preamble_restore}))
		else $error("control changed without a write");

	chk_latency_write: assert property (
		s_ctl_write |=> rx_latency_variable == ($past(wr_word[10])
		&& !RMII_VARIANT))
		else $error("latency select not written");

	chk_preamble_write: assert property (
		s_ctl_write |=> preamble_restore == $past(wr_word[6]))
		else $error("preamble restore not written");

	chk_enable_write: assert property (
		(wr_stb && reg_q == `PSC_REG_INTCS) |=> irq_en == $past(wr_word[15:8]))
		else $error("interrupt enables not written");

	chk_flag_no_write: assert property (
		wr_stb |=> (flags & ~$past(flags) & ~$past(evt)) == 8'h0)
		else $error("write reached an event flag");

	chk_strap_locked: assert property (
		strap_done |=> $stable({strap_pair, strap_chain, strap_is_rmii,
		strap_is_mii}))
		else $error("strap status moved after capture");

	chk_turnaround_zero: assert property (
		s_turnaround |-> mdio_oe && !mdio_out)
		else $error("turnaround not driven low");

endmodule

// *** hw/psc_params.svh ***
// Purpose: Offsets, field positions, reset values and counts of the
//          strap, control and event register bank.
// Assumes: Included by every design file that needs it.
// Notes:   Register offsets are management register numbers.
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register numbers
// ----------------------------------------------------------------------
`define PSC_REG_STRAP     5'h17
`define PSC_REG_EXPCTL    5'h18
`define PSC_REG_INTCS     5'h1b

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PSC_BIT_PAIR      6
`define PSC_BIT_CHAIN     5
`define PSC_BIT_RMII      1
`define PSC_BIT_MII       0
`define PSC_BIT_ESPD      11
`define PSC_BIT_LAT       10
`define PSC_BIT_PRE       6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PSC_ESPD_RST      1'b1
`define PSC_LAT_RST       1'b0
`define PSC_PRE_RST       1'b0
`define PSC_EXPCTL_LOW    6'h01
`define PSC_EN_RST        8'h00

// ----------------------------------------------------------------------
// Management frame codes and counts
// ----------------------------------------------------------------------
`define PSC_START         2'h1
`define PSC_OP_RD         2'h2
`define PSC_OP_WR         2'h1
`define PSC_PRE_LEN       32
`define PSC_STRAP_SETTLE  3'h4

`endif

// *** hw/psc_pkg.sv ***
// Purpose: Types shared by the strap, control and event register bank.
// Assumes: Nothing.
// Notes:   Numbers live in psc_params.svh.
package psc_pkg;

	// Management frame receiver states
	typedef enum logic [2:0] {
		MS_PRE,
		MS_HDR,
		MS_TA1,
		MS_TA2,
		MS_RD,
		MS_WTA,
		MS_WR
	} psc_mdio_st_t;

	typedef logic [15:0] psc_word_t;

endpackage

// *** hw/psc_sync.sv ***
// Purpose: Three-stage synchroniser for pins from outside mclk.
// Assumes: Inputs are slow against mclk.
// Notes:   A change is passed once stages two and three agree.
`timescale 1ns/100ps
module psc_sync #(
	parameter int W = 1                   // Number of bits
)(
	input  wire logic         mclk,       // Core clock
	input  wire logic         rst,        // Async reset, high
	input  wire logic [W-1:0] d,          // Raw pins
	output logic      [W-1:0] q           // Filtered, synchronous
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// ------------------------------------------------------------------
	// Shift chain
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Agreement filter, one bit at a time
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				q[i] <= 1'b0;
			end else if (s2[i] == s3[i]) begin
				q[i] <= s3[i];
			end
		end
	end

endmodule

// *** hw/psc_event_flags.sv ***
// Purpose: Sticky event flags cleared on read, and the interrupt line.
// Assumes: Events are one-cycle pulses on mclk.
// Notes:   An event in the clearing cycle keeps its flag set.
`timescale 1ns/100ps
module psc_event_flags #(
	parameter int W = 8                   // Number of events
)(
	input  wire logic         mclk,       // Core clock
	input  wire logic         rst,        // Async reset, high
	input  wire logic [W-1:0] evt,        // Event pulses
	input  wire logic         clr,        // Clear pulse on read
	input  wire logic [W-1:0] en,         // Interrupt enables
	output logic      [W-1:0] flags,      // Sticky flags
	output logic              irq         // Interrupt, high
);

	logic [W-1:0] next_flags;

	// ------------------------------------------------------------------
	// Flags: set wins over the read clear
	// ------------------------------------------------------------------
	for (genvar i = 0; i < W; i++) begin : g_flag
		assign next_flags[i] = (flags[i] & ~clr) | evt[i];

		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				flags[i] <= 1'b0;
			end else begin
				flags[i] <= next_flags[i];
			end
		end

		chk_flag_sets: assert property (@(posedge mclk) disable iff (rst)
			evt[i] |=> flags[i])
			else $error("event did not set its flag");

		chk_flag_clears: assert property (@(posedge mclk) disable iff (rst)
			(clr && !evt[i]) |=> !flags[i])
			else $error("flag survived its read");
	end

	// Interrupt follows enabled flags in the same cycle they change
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_flags & en);
		end
	end

	chk_irq_level: assert property (@(posedge mclk) disable iff (rst)
		##1 (irq == |(flags & $past(en))))
		else $error("interrupt does not match enabled flags");

endmodule

// *** sim/psc_mdio_host.sv ***
// Purpose: Station management host that runs clause-22 frames on MDIO.
// Assumes: Driven from the bench at falling mclk edges.
// Notes:   MDIO has a pull-up; half sets the MDC half period in mclk.
`timescale 1ns/100ps
`include "psc_params.svh"
module psc_mdio_host
	import psc_pkg::*;
(
	input  wire logic mclk,               // Core clock
	output logic      mdc,                // Management clock pin
	output logic      mdio_lvl,           // Resolved MDIO level
	input  wire logic mdio_out,           // Device drive value
	input  wire logic mdio_oe             // Device drive enable
);
	logic host_oe;                        // Host drives MDIO
	logic host_out;                       // Host drive value
	int   half;                           // MDC half period, mclk

	// ------------------------------------------------------------
	// Wire and idle state
	// ------------------------------------------------------------
	// Released line floats to the pull-up level
	assign mdio_lvl = mdio_oe ? mdio_out : (host_oe ? host_out : 1'b1);

	// MDC stands high between frames
	initial begin
		mdc = 1'b1;
		host_oe = 1'b0;
		host_out = 1'b1;
		half = 10;
	end

	// ------------------------------------------------------------
	// One frame: 32 ones, header, turnaround, 16 data bits
	// ------------------------------------------------------------
	// Data changes while MDC is low, read bits sampled before rise
	task automatic frame(input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] rg, input psc_word_t wd, output psc_word_t rd);
		logic [63:0] seq;
		seq = {32'hffffffff, `PSC_START, op, phy, rg, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 63; i >= 0; i--) begin
			@(negedge mclk);
			mdc = 1'b0;
			host_oe = (op == `PSC_OP_WR) || (i > 17);
			host_out = seq[i];
			repeat (half) @(negedge mclk);
			if (i < 16) begin
				rd[i] = mdio_lvl;
			end
			mdc = 1'b1;
			repeat (half - 1) @(negedge mclk);
		end
		@(negedge mclk);
		host_oe = 1'b0;
	endtask
endmodule

// *** sim/tb_phy_strap_ctrl_irq_regs.sv ***
// Purpose: Self-checking bench of the strap, control and event bank.
// Assumes: RMII device at address 5, MII device at 6, 32-one preamble.
// Notes:   Inputs change at falling mclk edges only.
`timescale 1ns/100ps
`include "psc_params.svh"
`define CHK(g, e) \
	begin \
		checked++; \
		if ((g) !== (e)) begin \
			failures++; \
			$display("Error at %0t: got %h expected %h", $time, (g), (e)); \
		end \
	end
module tb_phy_strap_ctrl_irq_regs
	import psc_pkg::*;
();
	localparam logic [4:0] PHY = 5'h05;   // Address from straps
	logic       mclk = 1'b0;              // Core clock
	logic       rst = 1'b1;               // Reset, high
	logic       mdc;                      // From host
	logic       mdio_lvl;                 // Resolved MDIO
	logic       mdio_out;                 // Device drive value
	logic       mdio_oe;                  // Device drive enable
	logic       mdio_out2;                // MII device drive value
	logic       mdio_oe2;                 // MII device drive enable
	logic       st_pair = 1'b1;           // Pairing strap
	logic       st_chain = 1'b1;          // Chain test strap
	logic       st_rmii = 1'b1;           // RMII strap
	logic       st_mii = 1'b1;            // MII strap
	logic [7:0] evt = 8'h00;              // Event pulses
	logic       espd_dis;                 // Power-down disable
	logic       lat_var;                  // Variable latency
	logic       lat_var2;                 // MII variable latency
	logic       pre_rst;                  // Preamble restore
	logic       irq;                      // Interrupt
	int         failures = 0;             // Mismatches
	int         checked = 0;              // Comparisons
	int         cycles = 0;               // Run length
	psc_word_t  rd;                       // Read data

	// ------------------------------------------------------------
	// Clock, device and host
	// ------------------------------------------------------------
	// 200 MHz core clock
	always #2.5 mclk = ~mclk;

	psc_regs #(.RMII_VARIANT(1'b1), .PRE_LEN(32)) u_dut (
		.mclk(mclk), .rst(rst), .mdc(mdc), .mdio_in(mdio_lvl),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.strap_phy_addr(3'h5), .strap_repeater_pairing(st_pair),
		.strap_chain_test(st_chain), .strap_rmii(st_rmii),
		.strap_mii(st_mii), .evt(evt),
		.energy_sense_powerdown_dis(espd_dis),
		.rx_latency_variable(lat_var), .preamble_restore(pre_rst),
		.irq(irq));

	// Second device, MII variant at address 6, on the same MDIO line
	psc_regs #(.RMII_VARIANT(1'b0), .PRE_LEN(32)) u_dut_mii (
		.mclk(mclk), .rst(rst), .mdc(mdc), .mdio_in(mdio_lvl),
		.mdio_out(mdio_out2), .mdio_oe(mdio_oe2),
		.strap_phy_addr(3'h6), .strap_repeater_pairing(st_pair),
		.strap_chain_test(st_chain), .strap_rmii(st_rmii),
		.strap_mii(st_mii), .evt(evt),
		.energy_sense_powerdown_dis(), .rx_latency_variable(lat_var2),
		.preamble_restore(), .irq());

	psc_mdio_host u_host (.mclk(mclk), .mdc(mdc), .mdio_lvl(mdio_lvl),
		.mdio_out(mdio_oe ? mdio_out : mdio_out2),
		.mdio_oe(mdio_oe | mdio_oe2));

	// Cuts a hang short
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 100000) begin
			failures++;
			$display("Error at %0t: run timed out", $time);
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic test_end(input string n);
		$display("test %s finished", n);
	endtask

	task automatic rd_reg(input logic [4:0] rg, output psc_word_t d);
		u_host.frame(`PSC_OP_RD, PHY, rg, 16'h0000, d);
	endtask

	task automatic wr_reg(input logic [4:0] rg, input psc_word_t wd);
		psc_word_t d;
		u_host.frame(`PSC_OP_WR, PHY, rg, wd, d);
	endtask

	// One-cycle event, then let flag and irq settle
	task automatic pulse(input int i);
		@(negedge mclk);
		evt = 8'h01 << i;
		@(negedge mclk);
		evt = 8'h00;
		repeat (2) @(negedge mclk);
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	// Main sequence
	initial begin
		repeat (2) @(negedge mclk);
		`CHK(espd_dis, 1'b1)
		`CHK(pre_rst, 1'b0)
		`CHK(irq, 1'b0)
		rst = 1'b0;
		repeat (10) @(negedge mclk);
		st_pair = 1'b0;
		rd_reg(`PSC_REG_STRAP, rd);
		`CHK(rd, 16'h0062)
		rd_reg(`PSC_REG_EXPCTL, rd);
		`CHK(rd, 16'h0801)
		rd_reg(`PSC_REG_INTCS, rd);
		`CHK(rd, 16'h0000)
		test_end("reset values");
		wr_reg(`PSC_REG_STRAP, 16'hffff);
		rd_reg(`PSC_REG_STRAP, rd);
		`CHK(rd, 16'h0062)
		wr_reg(`PSC_REG_EXPCTL, 16'hffff);
		rd_reg(`PSC_REG_EXPCTL, rd);
		`CHK(rd, 16'h0841)
		`CHK({espd_dis, lat_var, pre_rst}, 3'h5)
		wr_reg(`PSC_REG_EXPCTL, 16'h0000);
		u_host.half = 20;
		rd_reg(`PSC_REG_EXPCTL, rd);
		u_host.half = 10;
		`CHK(rd, 16'h0001)
		`CHK({espd_dis, pre_rst}, 2'h0)
		test_end("control");
		for (int i = 0; i < 8; i++) begin
			pulse(i);
			`CHK(irq, 1'b0)
			rd_reg(`PSC_REG_INTCS, rd);
			`CHK(rd, 16'h0001 << i)
			rd_reg(`PSC_REG_INTCS, rd);
			`CHK(rd, 16'h0000)
		end
		test_end("events");
		wr_reg(`PSC_REG_INTCS, 16'hff55);
		rd_reg(`PSC_REG_INTCS, rd);
		`CHK(rd, 16'hff00)
		for (int j = 0; j < 8; j++) begin
			wr_reg(`PSC_REG_INTCS, 16'h0100 << j);
			pulse((j + 1) % 8);
			`CHK(irq, 1'b0)
			pulse(j);
			`CHK(irq, 1'b1)
			rd_reg(`PSC_REG_INTCS, rd);
			`CHK(rd, (16'h0101 << j) | (16'h0001 << ((j + 1) % 8)))
			`CHK(irq, 1'b0)
		end
		test_end("enables");
		u_host.frame(`PSC_OP_WR, 5'h07, `PSC_REG_EXPCTL, 16'h0fff, rd);
		u_host.frame(`PSC_OP_RD, 5'h07, `PSC_REG_EXPCTL, 16'h0000, rd);
		`CHK(rd, 16'hffff)
		u_host.frame(2'h3, PHY, `PSC_REG_EXPCTL, 16'h0000, rd);
		`CHK(rd, 16'hffff)
		rd_reg(`PSC_REG_EXPCTL, rd);
		`CHK(rd, 16'h0001)
		rd_reg(5'h1c, rd);
		`CHK(rd, 16'h0000)
		test_end("refusals");
		u_host.frame(`PSC_OP_RD, 5'h06, `PSC_REG_STRAP, 16'h0000, rd);
		`CHK(rd, 16'h0021)
		u_host.frame(`PSC_OP_WR, 5'h06, `PSC_REG_EXPCTL, 16'hffff, rd);
		`CHK({lat_var2, lat_var}, 2'h2)
		u_host.frame(`PSC_OP_RD, 5'h06, `PSC_REG_EXPCTL, 16'h0000, rd);
		`CHK(rd, 16'h0c41)
		test_end("mii variant");
		wr_reg(`PSC_REG_EXPCTL, 16'h0040);
		wr_reg(`PSC_REG_INTCS, 16'hff00);
		pulse(3);
		`CHK(irq, 1'b1)
		rst = 1'b1;
		@(negedge mclk);
		`CHK({espd_dis, pre_rst, irq}, 3'h4)
		rst = 1'b0;
		repeat (10) @(negedge mclk);
		rd_reg(`PSC_REG_INTCS, rd);
		`CHK(rd, 16'h0000)
		rd_reg(`PSC_REG_EXPCTL, rd);
		`CHK(rd, 16'h0801)
		test_end("reset mid-run");
		give_verdict();
	end
endmodule
